/* adc_channel_start_control.sv */
// Converter channel decode, start sourcing, settling timer and bus decode
//
// Implementation choices: strobed register access and the placing of the registers.
module adc_channel_start_control (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] input_mode_switch,
  input wire logic [10:0] addr_switch,
  input wire logic [5:0] vector_switch,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [15:0] vector,
  input wire logic clock_overflow_input,
  input wire logic external_start_pin,
  input wire logic external_start_tab,
  input wire logic [11:0] sar_result,
  output logic [3:0] mux_pos,
  output logic [3:0] mux_neg,
  output logic diff_mode,
  output logic sample_hold,
  output logic sar_run
);
  typedef enum logic [1:0] {IDLE, SETTLE, CONVERT} state_t;

  // ----------------------------------------------------------------
  // Switch synchronisers
  // ----------------------------------------------------------------
  // Switches are static but still asynchronous to clk, so they get two flops
  logic [2:0] mode_meta_ff;
  logic [2:0] mode_sync_ff;
  logic [10:0] asw_meta_ff;
  logic [10:0] asw_sync_ff;
  logic [5:0] vsw_meta_ff;
  logic [5:0] vsw_sync_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_meta_ff <= adc_start_pkg::MODE_SINGLE;
      mode_sync_ff <= adc_start_pkg::MODE_SINGLE;
      asw_meta_ff <= 11'h000;
      asw_sync_ff <= 11'h000;
      vsw_meta_ff <= 6'h00;
      vsw_sync_ff <= 6'h00;
    end else begin
      mode_meta_ff <= input_mode_switch;
      mode_sync_ff <= mode_meta_ff;
      asw_meta_ff <= addr_switch;
      asw_sync_ff <= asw_meta_ff;
      vsw_meta_ff <= vector_switch;
      vsw_sync_ff <= vsw_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Address and channel decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [1:0] off);
    // Switch on means that line must be 0
    hit = (a[15:13] == adc_start_pkg::ADDR_FIXED_HI[15:13]) &&
          (a[12:2] == ~asw_sync_ff) && (a[1:0] == off);
  endfunction

  logic is_diff;
  assign is_diff = (mode_sync_ff != adc_start_pkg::MODE_SINGLE);

  logic [15:0] status_ff;
  logic [11:0] buf_ff;
  logic [15:0] rdata_ff;
  logic [15:0] vector_ff;
  state_t state_ff;
  logic [9:0] cnt_ff;
  logic unread_ff;
  logic [2:0] ext_sync_ff;
  logic [1:0] ovf_sync_ff;
  logic ovf_prev_ff;
  logic [3:0] pos_ff;
  logic [3:0] neg_ff;
  logic diff_ff;

  logic [5:0] mux_field;
  assign mux_field = status_ff[adc_start_pkg::BIT_MUX_HI:adc_start_pkg::BIT_MUX_LO];

  // ----------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------
  // Pin and tab are wired together as one active-low level, either low pulls it low
  logic ext_level;
  assign ext_level = external_start_pin & external_start_tab;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_sync_ff <= 3'h7;
      ovf_sync_ff <= 2'h0;
      ovf_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_level};
      ovf_sync_ff <= {ovf_sync_ff[0], clock_overflow_input};
      ovf_prev_ff <= ovf_sync_ff[1];
    end
  end

  logic ext_fall;
  logic ovf_rise;
  assign ext_fall = ext_sync_ff[2] & ~ext_sync_ff[1];
  assign ovf_rise = ovf_sync_ff[1] & ~ovf_prev_ff;

  logic wr_status;
  logic rd_buffer;
  logic sw_start;
  logic hw_start;
  logic any_start;
  logic conv_end;
  assign wr_status = wr && hit(bus_addr, adc_start_pkg::OFF_STATUS);
  assign rd_buffer = rd && hit(bus_addr, adc_start_pkg::OFF_BUFFER);
  assign sw_start = wr_status && wdata[adc_start_pkg::BIT_GO];
  assign hw_start = (ovf_rise && status_ff[adc_start_pkg::BIT_OVF_EN]) ||
                    (ext_fall && status_ff[adc_start_pkg::BIT_EXT_EN]);
  assign any_start = sw_start || hw_start;
  assign conv_end = (state_ff == CONVERT) && (cnt_ff == 10'h000);

  // ----------------------------------------------------------------
  // Sequencer: settle then approximate
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= IDLE;
      cnt_ff <= 10'h000;
    end else begin
      case (state_ff)
        IDLE: begin
          if (any_start) begin
            state_ff <= SETTLE;
            cnt_ff <= 10'(adc_start_pkg::SETTLE_CYC - 1);
          end
        end
        SETTLE: begin
          if (cnt_ff == 10'h000) begin
            state_ff <= CONVERT;
            cnt_ff <= 10'(adc_start_pkg::SAR_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 10'h001;
          end
        end
        CONVERT: begin
          if (cnt_ff == 10'h000) begin
            state_ff <= IDLE;
          end else begin
            cnt_ff <= cnt_ff - 10'h001;
          end
        end
        default: begin
          state_ff <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status register and result buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_ff <= adc_start_pkg::STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_ff[15] <= wdata[15];
        status_ff[13:8] <= wdata[13:8];
        status_ff[6:4] <= wdata[6:4];
        status_ff[0] <= wdata[0];
      end
      if (rd_buffer) begin
        status_ff[adc_start_pkg::BIT_DONE] <= 1'b0;
      end
      if (conv_end) begin
        status_ff[adc_start_pkg::BIT_GO] <= 1'b0;
        status_ff[adc_start_pkg::BIT_DONE] <= 1'b1;
      end
      // Set wins over a software clear in the same cycle
      if ((any_start && state_ff != IDLE) || (conv_end && unread_ff)) begin
        status_ff[adc_start_pkg::BIT_ERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unread_ff <= 1'b0;
      buf_ff <= 12'h000;
    end else if (conv_end) begin
      unread_ff <= 1'b1;
      buf_ff <= sar_result;
    end else if (rd_buffer) begin
      unread_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
    end else if (rd && hit(bus_addr, adc_start_pkg::OFF_STATUS)) begin
      rdata_ff <= status_ff;
    end else if (rd_buffer) begin
      rdata_ff <= {4'h0, buf_ff};
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Multiplexer select and vector
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_ff <= 4'h0;
      neg_ff <= 4'h0;
      diff_ff <= 1'b0;
      vector_ff <= adc_start_pkg::VEC_FIXED;
    end else begin
      diff_ff <= is_diff;
      if (is_diff) begin
        pos_ff <= {mux_field[3:1], 1'b0};
        neg_ff <= {mux_field[3:1], 1'b1};
      end else begin
        pos_ff <= mux_field[3:0];
        neg_ff <= 4'h0;
      end
      vector_ff <= adc_start_pkg::VEC_FIXED | {7'h00, vsw_sync_ff, 3'h0};
    end
  end

  assign rdata = rdata_ff;
  assign vector = vector_ff;
  assign mux_pos = pos_ff;
  assign mux_neg = neg_ff;
  assign diff_mode = diff_ff;
  assign sample_hold = (state_ff == CONVERT);
  assign sar_run = (state_ff == CONVERT);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence settle_s;
    (state_ff == SETTLE) [*8];
  endsequence

  sequence start_idle_s;
    (state_ff == IDLE) && any_start;
  endsequence

  sequence convert_s;
    sar_run [*8];
  endsequence

  // Settle runs 500 cycles: eight in the sequence, then the rest as a delay
  settle_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    start_idle_s |=> settle_s ##[493:493] (state_ff == CONVERT))
    else $error("settling interval wrong");
  no_early_sar_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == SETTLE && cnt_ff != 10'h000) |=> !sar_run)
    else $error("conversion before settle");
  diff_pair_a: assert property (@(posedge clk) disable iff (!resetn)
    is_diff |=> (mux_neg == mux_pos + 4'h1) && !mux_pos[0])
    else $error("bad differential pair");
  single_sel_a: assert property (@(posedge clk) disable iff (!resetn)
    !is_diff |=> (mux_pos == $past(mux_field[3:0])))
    else $error("bad single channel");
  ext_start_a: assert property (@(posedge clk) disable iff (!resetn)
    (ext_fall && status_ff[4] && state_ff == IDLE) |=> (state_ff == SETTLE))
    else $error("external start missed");
  ovf_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (ovf_rise && !status_ff[5] && !sw_start && !(ext_fall && status_ff[4]) && state_ff == IDLE)
    |=> (state_ff == IDLE))
    else $error("overflow start not gated");
  go_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    conv_end |=> !status_ff[0] && status_ff[7])
    else $error("go bit not cleared");
  err_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (any_start && state_ff != IDLE) |=> status_ff[15])
    else $error("error flag not set");
  vector_bits_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (vector[8:3] == $past(vsw_sync_ff)) && (vector[2:0] == 3'h0))
    else $error("vector bits wrong");

  // Approximation length is fixed; a stretched run would shift the result capture
  sar_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sar_run) |-> convert_s ##1 sar_run [*4] ##1 !sar_run)
    else $error("conversion length wrong");
  sw_start_a: assert property (@(posedge clk) disable iff (!resetn)
    (sw_start && state_ff == IDLE) |=> (state_ff == SETTLE) && status_ff[0])
    else $error("software start missed");
  ovf_start_a: assert property (@(posedge clk) disable iff (!resetn)
    (ovf_rise && status_ff[5] && state_ff == IDLE) |=> (state_ff == SETTLE))
    else $error("overflow start missed");
  ext_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (ext_fall && !status_ff[4] && !sw_start && !(ovf_rise && status_ff[5]) && state_ff == IDLE)
    |=> (state_ff == IDLE))
    else $error("external start not gated");
  err_overrun_a: assert property (@(posedge clk) disable iff (!resetn)
    (conv_end && unread_ff) |=> status_ff[15])
    else $error("overrun not flagged");
  err_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_status && !wdata[15] && !(any_start && state_ff != IDLE) && !(conv_end && unread_ff))
    |=> !status_ff[15])
    else $error("error flag not cleared");
  done_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (rd_buffer && !conv_end) |=> !status_ff[7])
    else $error("done flag not cleared");
  diff_lsb_a: assert property (@(posedge clk) disable iff (!resetn)
    is_diff |=> (mux_pos[3:1] == $past(mux_field[3:1])))
    else $error("pair select wrong");
  mode_diff_a: assert property (@(posedge clk) disable iff (!resetn)
    is_diff |=> diff_mode)
    else $error("differential mode missing");
  mode_single_a: assert property (@(posedge clk) disable iff (!resetn)
    !is_diff |=> !diff_mode && (mux_neg == 4'h0))
    else $error("single mode wrong");
  // Unmapped reads must not leak register contents onto the bus
  addr_miss_a: assert property (@(posedge clk) disable iff (!resetn)
    (rd && !hit(bus_addr, adc_start_pkg::OFF_STATUS) && !hit(bus_addr, adc_start_pkg::OFF_BUFFER))
    |=> (rdata == 16'h0000))
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !rd |=> (rdata == 16'h0000))
    else $error("read data not cleared");
endmodule // adc_channel_start_control

/* adc_start_pkg.sv */
// Constants for the converter channel and start control block
// Summary of operation
// - Mode switch positions two to five select true differential pairing of adjacent inputs.
// - Mode switch position one gives sixteen single-ended or pseudo-differential channels.
// - In differential mode the lowest channel field bit, status bit 8, is ignored.
// - In differential mode status bits 11 to 9 equal to n pick input 2n plus and 2n+1 minus.
// - Every start is followed by a ten microsecond settling wait before approximation.
// - Each falling edge of the synchronised external start input begins a conversion when enable bit 4 is set.
// - Register decode compares A12 down to A02 with switches; A15..A13 fixed, A1..A0 select the register.
// - An address switch that is on demands a 0; a vector switch that is on drives a 1.
// - Vector bits D3 to D8 come from six switches, all other vector bits are fixed.
// - The clock module overflow event is accepted as a start source.
// - The external start is one signal reachable from the connector pin or the tab.
// - Overflow starts need enable bit 5; external starts need enable bit 4.
// - Writing one to status bit 0 starts a conversion; hardware clears it at the end.
// - Error bit 15 sets on a start during conversion or on an unread result overrun.
package adc_start_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SETTLE_US = 10;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned SAR_CYC = 12;
  localparam logic [15:0] ADDR_FIXED_HI = 16'he000;
  localparam logic [15:0] VEC_FIXED = 16'h0000;
  localparam logic [1:0] OFF_STATUS = 2'h0;
  localparam logic [1:0] OFF_BUFFER = 2'h2;
  localparam int unsigned BIT_ERR = 15;
  localparam int unsigned BIT_MUX_HI = 13;
  localparam int unsigned BIT_MUX_LO = 8;
  localparam int unsigned BIT_DONE = 7;
  localparam int unsigned BIT_IE = 6;
  localparam int unsigned BIT_OVF_EN = 5;
  localparam int unsigned BIT_EXT_EN = 4;
  localparam int unsigned BIT_GO = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
endpackage

/* rtc_partner.sv */
// Real-time clock partner driving the overflow and trigger tabs
module rtc_partner (
  input wire logic clk,
  output logic event_out,
  output logic trigger_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Tab drivers
  // ----------------------------------------
  initial event_out = 1'b0;
  initial trigger_out = 1'b1;
  // Three cycles so an async sampler cannot miss the event
  task automatic overflow();
    @(posedge clk);
    event_out <= 1'b1;
    repeat (3) @(posedge clk);
    event_out <= 1'b0;
  endtask
  task automatic trigger();
    @(posedge clk);
    trigger_out <= 1'b0;
    repeat (3) @(posedge clk);
    trigger_out <= 1'b1;
  endtask
endmodule // rtc_partner

/* tb.sv */
// Self-checking bench for the converter channel and start control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] mode = 3'h1;
  logic [10:0] asw;
  logic [5:0] vsw;
  logic [15:0] bus_addr = 16'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic pin = 1'b1;
  logic [11:0] sar;
  logic [15:0] rdata, vector, sta, buf_a;
  logic [3:0] mux_pos, mux_neg;
  logic diff_mode, sample_hold, sar_run, ovf, tab;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int num_checks = 0;
  int seed = 45737;
  int n;
  always #10 clk = ~clk;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  adc_channel_start_control u_adc_channel_start_control (.clk(clk), .resetn(resetn),
    .input_mode_switch(mode), .addr_switch(asw), .vector_switch(vsw), .bus_addr(bus_addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vector(vector),
    .clock_overflow_input(ovf), .external_start_pin(pin), .external_start_tab(tab),
    .sar_result(sar), .mux_pos(mux_pos), .mux_neg(mux_neg), .diff_mode(diff_mode),
    .sample_hold(sample_hold), .sar_run(sar_run));
  rtc_partner u_rtc_partner (.clk(clk), .event_out(ovf), .trigger_out(tab));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A read queues its expected word; the monitor compares it
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    if (!w) exp_q.push_back(d);
    bus_addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Waits bounded, so a start that never comes shows as a zero length
  task automatic conv(input logic settle);
    n = 0;
    while (!sar_run && n < 700) begin
      @(posedge clk);
      n++;
    end
    if (settle) chk(16'(n >= 498 && n <= 502), 16'h1);
    chk(16'(sample_hold), 16'h1);
    n = 0;
    while (sar_run && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n), 16'(adc_start_pkg::SAR_CYC));
  endtask
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk(rdata, exp_q.pop_front());
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    asw = 11'($random(seed));
    vsw = 6'($random(seed));
    sar = 12'($random(seed));
    sta = {3'h7, ~asw, 2'h0};
    buf_a = sta + 16'h2;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // Switches pass two flops, then the vector register
    repeat (4) @(negedge clk);
    chk(vector, {7'h0, vsw, 3'h0});
    bus(0, sta, 16'h0);
    bus(0, sta ^ 16'h0010, 16'h0);
    bus(0, sta & 16'hdfff, 16'h0);
    bus(1, sta, 16'h0b00);
    for (int m = 1; m <= 5; m++) begin
      mode <= 3'(m);
      repeat (5) @(posedge clk);
      chk(16'(diff_mode), 16'(m != 1));
      chk(16'(mux_pos), (m == 1) ? 16'hb : 16'ha);
      if (m != 1) chk(16'(mux_neg), 16'hb);
      else chk(16'(mux_neg), 16'h0);
    end
    bus(1, sta, 16'h0001);
    conv(1);
    bus(0, sta, 16'h0080);
    bus(0, buf_a, {4'h0, sar});
    bus(0, sta, 16'h0000);
    bus(1, sta, 16'h0001);
    repeat (20) @(posedge clk);
    bus(1, sta, 16'h0001);
    conv(0);
    bus(0, sta, 16'h8080);
    bus(1, sta, 16'h0000);
    bus(0, buf_a, {4'h0, sar});
    // Both sources disabled: nothing may start
    pin <= 1'b0;
    u_rtc_partner.overflow();
    n = 0;
    repeat (600) @(posedge clk) n += sar_run;
    chk(16'(n), 16'h0);
    pin <= 1'b1;
    bus(1, sta, 16'h0010);
    pin <= 1'b0;
    conv(0);
    pin <= 1'b1;
    bus(0, buf_a, {4'h0, sar});
    u_rtc_partner.trigger();
    conv(0);
    bus(0, sta, 16'h0090);
    bus(0, buf_a, {4'h0, sar});
    bus(1, sta, 16'h0020);
    u_rtc_partner.overflow();
    conv(0);
    u_rtc_partner.overflow();
    conv(0);
    bus(0, sta, 16'h80a0);
    end_of_test();
  end
  initial begin
    #(20 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule // tb
